//--- logic/dmc_pkg.sv
package dmc_pkg;
  // ==========================================================
  // Register indices and field positions
  localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] IDX_MUTE_OVER = 7'h12;
  localparam logic [6:0] IDX_DISABLE_DEEMPH = 7'h13;
  localparam logic [6:0] IDX_FORMAT_ROLLOFF = 7'h14;
  localparam logic [6:0] IDX_RESERVED_TEST = 7'h15;
  localparam logic [6:0] IDX_ZERO_PHASE = 7'h16;
  localparam int WORD_BITS = 16;
  localparam int POS_TOP = 15;
  localparam int POS_IDX_HI = 14;
  localparam int POS_IDX_LO = 8;
  localparam int POS_LEFT_MUTE = 0;
  localparam int POS_RIGHT_MUTE = 1;
  localparam int POS_OVER = 6;
  localparam int POS_LEFT_DIS = 0;
  localparam int POS_RIGHT_DIS = 1;
  localparam int POS_DEEMPH_EN = 4;
  localparam int POS_DEEMPH_LO = 5;
  localparam int POS_FMT_LO = 0;
  localparam int POS_ROLLOFF = 5;
  localparam int POS_PHASE = 0;
  localparam int POS_ZPOL = 1;
  localparam int POS_ZCOMMON = 2;
  // ==========================================================
  // Attenuation codes and reset values
  localparam logic [7:0] ATTEN_RST = 8'hff;
  localparam logic [7:0] ATTEN_MUTE = 8'h80;
  localparam logic [1:0] DEEMPH_RST = 2'h0;
  localparam logic [2:0] FMT_RST = 3'h5;
  // ==========================================================
  // Ramp timing: eight sample periods per half-dB step
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int SAMPLE_RATE_HZ = 48_000;
  localparam int STEP_SAMPLES = 8;
  localparam int RAMP_STEP_CYC = STEP_SAMPLES * (SYS_CLK_HZ / SAMPLE_RATE_HZ);
  // ==========================================================
  // Settings carried to the datapath
  typedef struct packed {
    logic [7:0] left_atten_code;
    logic [7:0] right_atten_code;
    logic left_soft_mute;
    logic right_soft_mute;
    logic oversample_high;
    logic left_channel_disable;
    logic right_channel_disable;
    logic deemph_enable;
    logic [1:0] deemph_rate_sel;
    logic [2:0] audio_format_sel;
    logic rolloff_sel;
    logic common_zero_flag_sel;
    logic zero_flag_polarity;
    logic output_phase_invert;
  } dmc_cfg_s;
  localparam dmc_cfg_s CFG_RST = '{ATTEN_RST, ATTEN_RST, 1'b0, 1'b0, 1'b0,
    1'b0, 1'b0, 1'b0, DEEMPH_RST, FMT_RST, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage : dmc_pkg

//--- logic/dmc_ctrl_port.sv
`timescale 1ns/1ns
module dmc_ctrl_port #(
  parameter int RAMP_STEP_CYCLES = dmc_pkg::RAMP_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ctrl_bit_clock,
  input wire logic ctrl_serial_in,
  input wire logic ctrl_latch,
  input wire logic left_zero_detect,
  input wire logic right_zero_detect,
  output dmc_pkg::dmc_cfg_s cfg,
  output logic [7:0] left_level,
  output logic [7:0] right_level,
  output logic left_zero_flag,
  output logic right_zero_flag
);
  import dmc_pkg::*;

  // ==========================================================
  // Link domain: shift register on the control bit clock
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [14:0] shift_r, shift_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic done_tog_r, done_tog_nxt;
  logic link_clr;

  // Counter clears while the latch idles high; the clock is still then
  assign link_clr = rst | ctrl_latch;

  // Next shift state: one bit per clock, MSB first, stop at sixteen
  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    hold_nxt = hold_r;
    done_tog_nxt = done_tog_r;
    if (!ctrl_latch && bit_cnt_r < 5'h10) begin
      shift_nxt = {shift_r[13:0], ctrl_serial_in};
      bit_cnt_nxt = bit_cnt_r + 5'h01;
      if (bit_cnt_r == 5'h0f) begin
        hold_nxt = {shift_r, ctrl_serial_in};
        done_tog_nxt = ~done_tog_r;
      end
    end
  end

  // Bit counter, reset by the idle latch level
  always_ff @(posedge ctrl_bit_clock or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_r <= 5'h00;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // Shift and hold registers
  always_ff @(posedge ctrl_bit_clock or posedge rst) begin
    if (rst) begin
      shift_r <= 15'h0000;
      hold_r <= 16'h0000;
      done_tog_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      hold_r <= hold_nxt;
      done_tog_r <= done_tog_nxt;
    end
  end

  // ==========================================================
  // Crossing: toggle through three flops, latch level through two
  logic tog_s1_r, tog_s2_r, tog_s3_r, lat_s1_r, lat_s2_r;
  logic pend_r, pend_nxt, apply;

  // Synchronisers; the word in hold_r is static until the next frame
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
      lat_s1_r <= 1'b1;
      lat_s2_r <= 1'b1;
    end else begin
      tog_s1_r <= done_tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
      lat_s1_r <= ctrl_latch;
      lat_s2_r <= lat_s1_r;
    end
  end

  // Full word pending until the latch is seen high; set wins over clear
  assign apply = pend_r & lat_s2_r;
  always_comb begin
    pend_nxt = pend_r;
    if (apply) begin
      pend_nxt = 1'b0;
    end
    if (tog_s2_r ^ tog_s3_r) begin
      pend_nxt = 1'b1;
    end
  end

  // ==========================================================
  // Register bank write decode
  dmc_cfg_s cfg_r, cfg_nxt;
  logic [6:0] w_idx;
  logic [7:0] w_dat;

  assign w_idx = hold_r[POS_IDX_HI:POS_IDX_LO];
  assign w_dat = hold_r[7:0];

  // Field update per index; others and bad words are dropped
  always_comb begin
    cfg_nxt = cfg_r;
    if (apply && !hold_r[POS_TOP]) begin
      unique case (w_idx)
        IDX_LEFT_ATTEN: begin
          cfg_nxt.left_atten_code = w_dat;
        end
        IDX_RIGHT_ATTEN: begin
          cfg_nxt.right_atten_code = w_dat;
        end
        IDX_MUTE_OVER: begin
          cfg_nxt.left_soft_mute = w_dat[POS_LEFT_MUTE];
          cfg_nxt.right_soft_mute = w_dat[POS_RIGHT_MUTE];
          cfg_nxt.oversample_high = w_dat[POS_OVER];
        end
        IDX_DISABLE_DEEMPH: begin
          cfg_nxt.left_channel_disable = w_dat[POS_LEFT_DIS];
          cfg_nxt.right_channel_disable = w_dat[POS_RIGHT_DIS];
          cfg_nxt.deemph_enable = w_dat[POS_DEEMPH_EN];
          cfg_nxt.deemph_rate_sel = w_dat[POS_DEEMPH_LO +: 2];
        end
        IDX_FORMAT_ROLLOFF: begin
          cfg_nxt.audio_format_sel = w_dat[POS_FMT_LO +: 3];
          cfg_nxt.rolloff_sel = w_dat[POS_ROLLOFF];
        end
        IDX_ZERO_PHASE: begin
          cfg_nxt.output_phase_invert = w_dat[POS_PHASE];
          cfg_nxt.zero_flag_polarity = w_dat[POS_ZPOL];
          cfg_nxt.common_zero_flag_sel = w_dat[POS_ZCOMMON];
        end
        default: begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
  end

  // Settings and pending flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_r <= CFG_RST;
      pend_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ==========================================================
  // Attenuation ramp: one step per eight sample periods
  logic [15:0] step_cnt_r, step_cnt_nxt;
  logic tick_r, tick_nxt;

  // Step timer
  always_comb begin
    tick_nxt = 1'b0;
    step_cnt_nxt = step_cnt_r + 16'h0001;
    if (step_cnt_r == 16'(RAMP_STEP_CYCLES - 1)) begin
      step_cnt_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      step_cnt_r <= step_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  logic [7:0] lvl_r [2];
  logic [7:0] lvl_nxt [2];
  logic [7:0] tgt [2];

  // Per-channel ramp toward code, or toward mute floor
  for (genvar ch = 0; ch < 2; ch++) begin : g_ramp
    logic [7:0] code;
    logic mute;
    assign code = ch == 0 ? cfg_r.left_atten_code : cfg_r.right_atten_code;
    assign mute = ch == 0 ? cfg_r.left_soft_mute : cfg_r.right_soft_mute;
    // Codes at or below 128 all mean infinite attenuation
    assign tgt[ch] = (mute || code <= ATTEN_MUTE) ? ATTEN_MUTE : code;
    always_comb begin
      lvl_nxt[ch] = lvl_r[ch];
      if (tick_r && lvl_r[ch] < tgt[ch]) begin
        lvl_nxt[ch] = lvl_r[ch] + 8'h01;
      end else if (tick_r && lvl_r[ch] > tgt[ch]) begin
        lvl_nxt[ch] = lvl_r[ch] - 8'h01;
      end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        lvl_r[ch] <= ATTEN_RST;
      end else begin
        lvl_r[ch] <= lvl_nxt[ch];
      end
    end
  end

  // ==========================================================
  // Zero flags: polarity and shared-flag selection
  logic zl_r, zr_r, zl_nxt, zr_nxt;

  always_comb begin
    zl_nxt = left_zero_detect ^ cfg_r.zero_flag_polarity;
    zr_nxt = right_zero_detect ^ cfg_r.zero_flag_polarity;
    if (cfg_r.common_zero_flag_sel) begin
      zl_nxt = 1'b0;
      zr_nxt = (left_zero_detect & right_zero_detect)
               ^ cfg_r.zero_flag_polarity;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zl_r <= 1'b0;
      zr_r <= 1'b0;
    end else begin
      zl_r <= zl_nxt;
      zr_r <= zr_nxt;
    end
  end

  // Outputs straight from flops
  assign cfg = cfg_r;
  assign left_level = lvl_r[0];
  assign right_level = lvl_r[1];
  assign left_zero_flag = zl_r;
  assign right_zero_flag = zr_r;

  // ==========================================================
  // Checks; two clock domains, so each names its own clock
  a_level_floor: assert property (
    @(posedge clk_sys) disable iff (rst) lvl_r[0] >= ATTEN_MUTE)
    else $error("left level below mute floor");
  a_right_floor: assert property (
    @(posedge clk_sys) disable iff (rst) lvl_r[1] >= ATTEN_MUTE)
    else $error("right level below mute floor");
  a_step_on_tick: assert property (
    @(posedge clk_sys) disable iff (rst) !tick_r |=> $stable(lvl_r[0]))
    else $error("level moved without step tick");
  a_mute_ramp_down: assert property (
    @(posedge clk_sys) disable iff (rst)
    tick_r && cfg_r.left_soft_mute && lvl_r[0] > ATTEN_MUTE
    |=> lvl_r[0] == $past(lvl_r[0]) - 8'h01)
    else $error("soft mute did not step down");
  a_unmute_ramp_up: assert property (
    @(posedge clk_sys) disable iff (rst)
    tick_r && lvl_r[0] < tgt[0] |=> lvl_r[0] == $past(lvl_r[0]) + 8'h01)
    else $error("level did not step up");
  a_left_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    apply && !hold_r[POS_TOP] && w_idx == IDX_LEFT_ATTEN
    |=> cfg_r.left_atten_code == $past(w_dat))
    else $error("left code not written");
  a_right_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    apply && !hold_r[POS_TOP] && w_idx == IDX_RIGHT_ATTEN
    |=> cfg_r.right_atten_code == $past(w_dat)
    && cfg_r.left_atten_code == $past(cfg_r.left_atten_code))
    else $error("right code not written");
  a_bad_word_ignored: assert property (
    @(posedge clk_sys) disable iff (rst)
    apply && (hold_r[POS_TOP] || w_idx == IDX_RESERVED_TEST
    || w_idx < IDX_LEFT_ATTEN || w_idx > IDX_ZERO_PHASE)
    |=> $stable(cfg_r))
    else $error("bad word changed settings");
  a_write_on_latch: assert property (
    @(posedge clk_sys) disable iff (rst)
    !lat_s2_r |=> $stable(cfg_r))
    else $error("settings changed while latch low");
  a_common_flag: assert property (
    @(posedge clk_sys) disable iff (rst)
    cfg_r.common_zero_flag_sel ##1 cfg_r.common_zero_flag_sel |-> !zl_r)
    else $error("unassigned flag pin driven");
  a_flag_polarity: assert property (
    @(posedge clk_sys) disable iff (rst)
    !cfg_r.common_zero_flag_sel && !cfg_r.zero_flag_polarity
    |=> zr_r == $past(right_zero_detect))
    else $error("right zero flag wrong");
  a_flag_inverted: assert property (
    @(posedge clk_sys) disable iff (rst)
    !cfg_r.common_zero_flag_sel && cfg_r.zero_flag_polarity
    |=> zr_r == !$past(right_zero_detect))
    else $error("inverted right zero flag wrong");
  a_frame_bits: assert property (
    @(posedge ctrl_bit_clock) disable iff (rst) bit_cnt_r <= 5'h10)
    else $error("bit count passed sixteen");

  // Main scenarios worth seeing in a run
  c_write: cover property (
    @(posedge clk_sys) disable iff (rst) apply && w_idx == IDX_MUTE_OVER);
  c_mute_done: cover property (@(posedge clk_sys) disable iff (rst)
    cfg_r.left_soft_mute && lvl_r[0] == ATTEN_MUTE);
  c_common: cover property (@(posedge clk_sys) disable iff (rst)
    cfg_r.common_zero_flag_sel && zr_r);
  c_bad_word: cover property (
    @(posedge clk_sys) disable iff (rst) apply && hold_r[POS_TOP]);
  c_ramp_up: cover property (@(posedge clk_sys) disable iff (rst)
    tick_r && !cfg_r.left_soft_mute && lvl_r[0] < tgt[0]);
endmodule : dmc_ctrl_port

//--- dv/dmc_host_model.sv
`timescale 1ns/1ns
module dmc_host_model (
  output logic ctrl_bit_clock,
  output logic ctrl_serial_in,
  output logic ctrl_latch
);
  // ==========================================================
  // Idle state: latch high, bit clock still, data at pull-down
  initial begin
    ctrl_bit_clock = 1'b0;
    ctrl_serial_in = 1'b0;
    ctrl_latch = 1'b1;
  end

  // One frame of nclk bits, 32 ns bit clock, MSB first
  task automatic send_word(input logic [15:0] word, input int nclk);
    ctrl_latch = 1'b0;
    #20;
    for (int i = 0; i < nclk; i++) begin
      ctrl_serial_in = i < 16 ? word[15 - i] : 1'b0;
      #16 ctrl_bit_clock = 1'b1;
      #16 ctrl_bit_clock = 1'b0;
    end
    // Released data line falls to its pull-down level
    ctrl_serial_in = 1'b0;
    #4 ctrl_latch = 1'b1;
    #400;
  endtask : send_word
endmodule : dmc_host_model

//--- dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import dmc_pkg::*;
  localparam int STEP = 8;
  logic clk_sys, rst, l_det, r_det;
  logic ctrl_bit_clock, ctrl_serial_in, ctrl_latch;
  dmc_cfg_s cfg, exp_cfg;
  logic [7:0] left_level, right_level;
  logic left_zero_flag, right_zero_flag;
  int err_count, n_checks;

  dmc_host_model u_dmc_host_model (.ctrl_bit_clock(ctrl_bit_clock),
    .ctrl_serial_in(ctrl_serial_in), .ctrl_latch(ctrl_latch));
  dmc_ctrl_port #(.RAMP_STEP_CYCLES(STEP)) u_dmc_ctrl_port (
    .clk_sys(clk_sys), .rst(rst), .ctrl_bit_clock(ctrl_bit_clock),
    .ctrl_serial_in(ctrl_serial_in), .ctrl_latch(ctrl_latch),
    .left_zero_detect(l_det), .right_zero_detect(r_det), .cfg(cfg),
    .left_level(left_level), .right_level(right_level),
    .left_zero_flag(left_zero_flag), .right_zero_flag(right_zero_flag));

  // ==========================================================
  // Clock, reset and shared helpers
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cycles

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  // Full frame, then time for the word to cross into clk_sys
  task automatic wr(input logic [6:0] idx, input logic [7:0] data);
    u_dmc_host_model.send_word({1'b0, idx, data}, 16);
    cycles(8);
  endtask : wr

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Scenarios
  task automatic test_reset;
    chk(cfg === CFG_RST, "reset settings");
    chk(cfg.audio_format_sel === 3'h5, "reset format");
    chk(left_level === 8'hff && right_level === 8'hff, "levels");
    chk(left_zero_flag === 1'b0, "reset flag");
    $display("test reset done");
  endtask : test_reset

  task automatic test_fields;
    wr(IDX_MUTE_OVER, 8'h40);
    exp_cfg.oversample_high = 1'b1;
    chk(cfg === exp_cfg, "oversample");
    for (int r = 0; r < 3; r++) begin
      wr(IDX_DISABLE_DEEMPH, {1'b0, r[1:0], 1'b1, 2'b00, 2'b11});
      exp_cfg.deemph_rate_sel = r[1:0];
      exp_cfg.deemph_enable = 1'b1;
      exp_cfg.left_channel_disable = 1'b1;
      exp_cfg.right_channel_disable = 1'b1;
      chk(cfg === exp_cfg, "deemph");
    end
    for (int f = 0; f < 6; f++) begin
      wr(IDX_FORMAT_ROLLOFF, {2'b00, 1'b1, 2'b00, f[2:0]});
      exp_cfg.audio_format_sel = f[2:0];
      exp_cfg.rolloff_sel = 1'b1;
      chk(cfg === exp_cfg, "format");
    end
    wr(IDX_ZERO_PHASE, 8'h01);
    exp_cfg.output_phase_invert = 1'b1;
    chk(cfg === exp_cfg, "phase");
    $display("test fields done");
  endtask : test_fields

  task automatic test_refused;
    wr(IDX_RESERVED_TEST, 8'hff);
    wr(7'h17, 8'h00);
    wr(7'h0f, 8'h00);
    u_dmc_host_model.send_word({1'b1, IDX_LEFT_ATTEN, 8'h00}, 16);
    u_dmc_host_model.send_word({1'b0, IDX_FORMAT_ROLLOFF, 8'h24}, 17);
    exp_cfg.audio_format_sel = 3'h4;
    u_dmc_host_model.send_word({1'b0, IDX_LEFT_ATTEN, 8'h00}, 15);
    cycles(8);
    chk(cfg === exp_cfg, "refused word");
    chk(left_level === 8'hff, "refused level");
    $display("test refused done");
  endtask : test_refused

  task automatic test_ramp;
    wr(IDX_LEFT_ATTEN, 8'hfe);
    exp_cfg.left_atten_code = 8'hfe;
    chk(cfg === exp_cfg, "left code");
    cycles(2 * STEP + 2);
    chk(left_level === 8'hfe, "left level");
    wr(IDX_RIGHT_ATTEN, 8'h00);
    exp_cfg.right_atten_code = 8'h00;
    chk(right_level inside {[8'hfc:8'hfe]}, "no jump");
    cycles(130 * STEP);
    chk(right_level === 8'h80, "right muted");
    chk(left_level === 8'hfe, "left kept");
    $display("test ramp done");
  endtask : test_ramp

  task automatic test_mute;
    wr(IDX_MUTE_OVER, 8'h43);
    exp_cfg.left_soft_mute = 1'b1;
    exp_cfg.right_soft_mute = 1'b1;
    chk(cfg === exp_cfg, "mute set");
    cycles(130 * STEP);
    chk(left_level === 8'h80, "soft muted");
    wr(IDX_MUTE_OVER, 8'h40);
    exp_cfg.left_soft_mute = 1'b0;
    exp_cfg.right_soft_mute = 1'b0;
    chk(cfg === exp_cfg, "mute clear");
    cycles(4 * STEP);
    chk(left_level > 8'h80 && left_level < 8'hfe, "ramp up");
    cycles(130 * STEP);
    chk(left_level === 8'hfe, "restored");
    $display("test mute done");
  endtask : test_mute

  task automatic test_flags;
    l_det = 1'b1;
    cycles(3);
    chk(left_zero_flag === 1'b1, "left flag");
    chk(right_zero_flag === 1'b0, "right flag");
    wr(IDX_ZERO_PHASE, 8'h03);
    chk(left_zero_flag === 1'b0, "left inv");
    chk(right_zero_flag === 1'b1, "right inv");
    wr(IDX_ZERO_PHASE, 8'h06);
    r_det = 1'b1;
    cycles(3);
    chk(right_zero_flag === 1'b0, "common both");
    r_det = 1'b0;
    cycles(3);
    chk(right_zero_flag === 1'b1, "common one");
    chk(left_zero_flag === 1'b0, "unassigned");
    $display("test flags done");
  endtask : test_flags

  // Reset again in mid-run, after settings and levels have moved
  task automatic test_reset_mid;
    l_det = 1'b0;
    rst = 1'b1;
    cycles(2);
    rst = 1'b0;
    exp_cfg = CFG_RST;
    cycles(2);
    test_reset();
    $display("test reset_mid done");
  endtask : test_reset_mid

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    err_count = 0;
    n_checks = 0;
    rst = 1'b1;
    l_det = 1'b0;
    r_det = 1'b0;
    exp_cfg = CFG_RST;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    cycles(2);
    test_reset();
    test_fields();
    test_refused();
    test_ramp();
    test_mute();
    test_flags();
    test_reset_mid();
    print_verdict();
  end

  initial begin
    #2_000_000;
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule : tb_top
